// ==== memtest_defines.svh ====
// constants for the serial to memory bridge
`ifndef MEMTEST_DEFINES_SVH
`define MEMTEST_DEFINES_SVH
`define CLK_HZ 50000000
`define BAUD_RATE 115200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define FRAME_DATA_BITS 4'h9
`define FRAME_STOP_BIT 4'h9
`define CMD_WRITE_BIT 0
`define CMD_BURST_BIT 1
`define ADDR_LAST_BYTE 4'h4
`define DATA_LAST_BYTE 4'hc
`define BURSTS_DEFAULT 16
`define BEATS_DEFAULT 16
`define BYTES_PER_BEAT 8
`define RB_WORDS 256
`define SINGLE_LAST_BYTE 11'h007
`define BURST_LAST_BYTE 11'h7ff
`define AXI_SIZE_8B 3'h3
`define AXI_BURST_INCR 2'h1
`define AXI_STRB_ALL 8'hff
`endif

// ==== memtest_pkg.sv ====
// types shared by the serial to memory bridge
package memtest_pkg;
	typedef enum logic [7:0] {
		ST_GET = 8'h01,
		ST_AW = 8'h02,
		ST_W = 8'h04,
		ST_B = 8'h08,
		ST_AR = 8'h10,
		ST_R = 8'h20,
		ST_SEND = 8'h40,
		ST_SPARE = 8'h80
	} state_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] len;
		logic [2:0] size;
		logic [1:0] burst;
	} axi_addr_t;
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] strb;
		logic last;
	} axi_w_t;
	typedef struct packed {
		logic [63:0] data;
		logic last;
	} axi_r_t;
endpackage : memtest_pkg

// ==== serial_command_wrapper.sv ====
// serial command bridge with built-in serial core and AXI master engine
`timescale 1ns/1ns
`include "memtest_defines.svh"

module serial_command_wrapper #(
	parameter int BURSTS = `BURSTS_DEFAULT,
	parameter int BEATS = `BEATS_DEFAULT,
	// clocks per serial bit; keep at 8 or more for the start-bit check
	parameter int BAUD_DIV = `BIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic rx_i,
	output logic tx_o,
	output memtest_pkg::axi_addr_t aw_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output memtest_pkg::axi_w_t w_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output memtest_pkg::axi_addr_t ar_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input memtest_pkg::axi_r_t r_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	localparam logic [15:0] BIT_CNT = 16'(BAUD_DIV - 1);
	localparam logic [15:0] HALF_CNT = 16'(BAUD_DIV / 2 - 1);
	localparam logic [3:0] LAST_BEAT = 4'(BEATS - 1);
	localparam logic [3:0] LAST_BURST = 4'(BURSTS - 1);
	localparam logic [31:0] BURST_STEP = 32'(BEATS * `BYTES_PER_BEAT);

	// ----------------------------------------
	// serial receiver
	// ----------------------------------------
	logic [2:0] rx_sync_q;
	logic rx_filt_q, rx_filt_d, rx_busy_q, rx_busy_d, rx_valid_q, rx_valid_d;
	logic [15:0] rx_cnt_q, rx_cnt_d;
	logic [3:0] rx_bit_q, rx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d;

	always_comb begin
		// a level counts only once the second and third stages agree
		rx_filt_d = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_filt_q;
		rx_busy_d = rx_busy_q;
		rx_cnt_d = rx_cnt_q;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_valid_d = 1'b0;
		if (!rx_busy_q) begin
			if (!rx_filt_q) begin
				rx_busy_d = 1'b1;
				rx_cnt_d = HALF_CNT;
				rx_bit_d = 4'h0;
			end
		end else if (rx_cnt_q != 16'h0000) begin
			rx_cnt_d = rx_cnt_q - 16'h0001;
		end else begin
			rx_cnt_d = BIT_CNT;
			rx_bit_d = rx_bit_q + 4'h1;
			if (rx_bit_q == 4'h0) begin
				rx_busy_d = ~rx_filt_q; // glitch shorter than half a bit is dropped
			end else if (rx_bit_q == `FRAME_STOP_BIT) begin
				rx_busy_d = 1'b0;
				rx_valid_d = rx_filt_q; // bad stop bit discards the byte
			end else begin
				rx_sh_d = {rx_filt_q, rx_sh_q[7:1]};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rx_sync_q <= 3'h7;
			rx_filt_q <= 1'b1;
			rx_busy_q <= 1'b0;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], rx_i};
			rx_filt_q <= rx_filt_d;
			rx_busy_q <= rx_busy_d;
			rx_cnt_q <= rx_cnt_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			rx_valid_q <= rx_valid_d;
		end
	end

	// ----------------------------------------
	// serial transmitter
	// ----------------------------------------
	logic tx_start;
	logic [7:0] tx_byte;
	logic [8:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_left_q, tx_left_d;
	logic [15:0] tx_cnt_q, tx_cnt_d;
	logic tx_q, tx_d, tx_busy;

	assign tx_busy = (tx_left_q != 4'h0) || (tx_cnt_q != 16'h0000);
	assign tx_o = tx_q;

	always_comb begin
		tx_sh_d = tx_sh_q;
		tx_left_d = tx_left_q;
		tx_cnt_d = tx_cnt_q;
		tx_d = tx_q;
		if (tx_start) begin
			tx_sh_d = {1'b1, tx_byte};
			tx_left_d = `FRAME_DATA_BITS;
			tx_cnt_d = BIT_CNT;
			tx_d = 1'b0;
		end else if (tx_cnt_q != 16'h0000) begin
			tx_cnt_d = tx_cnt_q - 16'h0001;
		end else if (tx_left_q != 4'h0) begin
			tx_d = tx_sh_q[0];
			tx_sh_d = {1'b1, tx_sh_q[8:1]};
			tx_left_d = tx_left_q - 4'h1;
			tx_cnt_d = BIT_CNT;
		end else begin
			tx_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			tx_sh_q <= 9'h1ff;
			tx_left_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			tx_q <= 1'b1;
		end else begin
			tx_sh_q <= tx_sh_d;
			tx_left_q <= tx_left_d;
			tx_cnt_q <= tx_cnt_d;
			tx_q <= tx_d;
		end
	end

	// ----------------------------------------
	// command sequencer and master engine
	// ----------------------------------------
	memtest_pkg::state_t st_q, st_d;
	logic [1:0] cmd_q, cmd_d;
	logic [31:0] addr_q, addr_d;
	logic [63:0] data_q, data_d;
	logic [3:0] hcnt_q, hcnt_d, beat_q, beat_d, bcnt_q, bcnt_d;
	logic [7:0] widx_q, widx_d;
	logic [10:0] sidx_q, sidx_d;
	logic [63:0] rb_mem [`RB_WORDS];
	logic [63:0] rb_word;
	logic burst, rb_we;

	assign burst = cmd_q[`CMD_BURST_BIT];
	assign aw_o = '{addr: addr_q, len: {4'h0, burst ? LAST_BEAT : 4'h0}, size: `AXI_SIZE_8B, burst: `AXI_BURST_INCR};
	assign ar_o = aw_o;
	assign w_o = '{data: data_q, strb: `AXI_STRB_ALL, last: !burst || (beat_q == LAST_BEAT)};
	assign awvalid_o = (st_q == memtest_pkg::ST_AW);
	assign wvalid_o = (st_q == memtest_pkg::ST_W);
	assign bready_o = (st_q == memtest_pkg::ST_B);
	assign arvalid_o = (st_q == memtest_pkg::ST_AR);
	assign rready_o = (st_q == memtest_pkg::ST_R);
	assign rb_we = rready_o && rvalid_i;
	assign rb_word = rb_mem[sidx_q[10:3]];
	assign tx_byte = rb_word[{~sidx_q[2:0], 3'h0} +: 8];

	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		data_d = data_q;
		hcnt_d = hcnt_q;
		beat_d = beat_q;
		bcnt_d = bcnt_q;
		widx_d = widx_q;
		sidx_d = sidx_q;
		tx_start = 1'b0;
		case (st_q)
			memtest_pkg::ST_GET: begin
				if (rx_valid_q) begin
					hcnt_d = hcnt_q + 4'h1;
					if (hcnt_q == 4'h0) begin
						cmd_d = rx_sh_q[1:0];
					end else if (hcnt_q <= `ADDR_LAST_BYTE) begin
						addr_d = {addr_q[23:0], rx_sh_q};
					end else begin
						data_d = {data_q[55:0], rx_sh_q};
					end
					if (hcnt_q == (cmd_q[`CMD_WRITE_BIT] ? `DATA_LAST_BYTE : `ADDR_LAST_BYTE)) begin
						hcnt_d = 4'h0;
						beat_d = 4'h0;
						bcnt_d = 4'h0;
						widx_d = 8'h00;
						st_d = cmd_q[`CMD_WRITE_BIT] ? memtest_pkg::ST_AW : memtest_pkg::ST_AR;
					end
				end
			end
			memtest_pkg::ST_AW: begin
				if (awready_i) begin
					st_d = memtest_pkg::ST_W;
				end
			end
			memtest_pkg::ST_W: begin
				if (wready_i) begin
					beat_d = beat_q + 4'h1;
					if (burst) begin
						data_d = data_q + 64'h1;
					end
					if (w_o.last) begin
						beat_d = 4'h0;
						st_d = memtest_pkg::ST_B;
					end
				end
			end
			memtest_pkg::ST_B: begin
				if (bvalid_i) begin
					st_d = memtest_pkg::ST_GET;
					if (burst && (bcnt_q != LAST_BURST)) begin
						bcnt_d = bcnt_q + 4'h1;
						addr_d = addr_q + BURST_STEP;
						st_d = memtest_pkg::ST_AW;
					end
				end
			end
			memtest_pkg::ST_AR: begin
				if (arready_i) begin
					st_d = memtest_pkg::ST_R;
				end
			end
			memtest_pkg::ST_R: begin
				if (rvalid_i) begin
					widx_d = widx_q + 8'h01;
					if (r_i.last) begin
						if (burst && (bcnt_q != LAST_BURST)) begin
							bcnt_d = bcnt_q + 4'h1;
							addr_d = addr_q + BURST_STEP;
							st_d = memtest_pkg::ST_AR;
						end else begin
							sidx_d = 11'h000;
							st_d = memtest_pkg::ST_SEND;
						end
					end
				end
			end
			memtest_pkg::ST_SEND: begin
				if (!tx_busy) begin
					tx_start = 1'b1;
					sidx_d = sidx_q + 11'h001;
					if (sidx_q == (burst ? `BURST_LAST_BYTE : `SINGLE_LAST_BYTE)) begin
						st_d = memtest_pkg::ST_GET;
					end
				end
			end
			default: begin
				st_d = memtest_pkg::ST_GET;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_q <= memtest_pkg::ST_GET;
			cmd_q <= 2'h0;
			addr_q <= 32'h00000000;
			data_q <= 64'h0;
			hcnt_q <= 4'h0;
			beat_q <= 4'h0;
			bcnt_q <= 4'h0;
			widx_q <= 8'h00;
			sidx_q <= 11'h000;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			data_q <= data_d;
			hcnt_q <= hcnt_d;
			beat_q <= beat_d;
			bcnt_q <= bcnt_d;
			widx_q <= widx_d;
			sidx_q <= sidx_d;
		end
	end

	// buffer needs no reset; contents are only read after being written
	always_ff @(posedge sys_clk_i) begin
		if (rb_we) begin
			rb_mem[widx_q] <= r_i.data;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_awlen;
		@(posedge sys_clk_i) disable iff (!resetn_i) awvalid_o |-> aw_o.len == (burst ? 8'h0f : 8'h00);
	endproperty
	a_awlen: assert property (p_awlen) else $error("awlen does not match transfer form");
	property p_aw_hold;
		@(posedge sys_clk_i) disable iff (!resetn_i) awvalid_o && !awready_i |=> awvalid_o && $stable(aw_o.addr);
	endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("write address dropped before ready");
	property p_wdata_inc;
		@(posedge sys_clk_i) disable iff (!resetn_i) wvalid_o && wready_i && burst |=> w_o.data == $past(w_o.data) + 64'h1;
	endproperty
	a_wdata_inc: assert property (p_wdata_inc) else $error("burst data not incremented");
	property p_single_data;
		@(posedge sys_clk_i) disable iff (!resetn_i) wvalid_o && wready_i && !burst |=> $stable(w_o.data) && bready_o;
	endproperty
	a_single_data: assert property (p_single_data) else $error("single write data changed");
	property p_wlast;
		@(posedge sys_clk_i) disable iff (!resetn_i) wvalid_o && w_o.last && burst |-> beat_q == 4'hf;
	endproperty
	a_wlast: assert property (p_wlast) else $error("wlast on wrong beat");
	property p_send_only;
		@(posedge sys_clk_i) disable iff (!resetn_i) tx_start |-> st_q == memtest_pkg::ST_SEND && !tx_busy;
	endproperty
	a_send_only: assert property (p_send_only) else $error("transmit outside readback");
	property p_ignore_rx;
		@(posedge sys_clk_i) disable iff (!resetn_i) rx_valid_q && st_q != memtest_pkg::ST_GET |=> $stable(cmd_q) && hcnt_q == 4'h0;
	endproperty
	a_ignore_rx: assert property (p_ignore_rx) else $error("byte accepted while busy");
	property p_buf_wr;
		@(posedge sys_clk_i) disable iff (!resetn_i) rb_we |=> widx_q == $past(widx_q) + 8'h01;
	endproperty
	a_buf_wr: assert property (p_buf_wr) else $error("read word not stored");
	property p_tx_start_bit;
		@(posedge sys_clk_i) disable iff (!resetn_i) tx_start |=> !tx_o [*8];
	endproperty
	a_tx_start_bit: assert property (p_tx_start_bit) else $error("start bit too short");
	c_single_write: cover property (@(posedge sys_clk_i) bvalid_i && bready_o && !burst);
	c_burst_write: cover property (@(posedge sys_clk_i) bvalid_i && bready_o && burst && bcnt_q == 4'hf);
	c_single_read: cover property (@(posedge sys_clk_i) tx_start && !burst && sidx_q == 11'h007);
	c_burst_read: cover property (@(posedge sys_clk_i) tx_start && burst && sidx_q == 11'h7ff);
endmodule : serial_command_wrapper

// ==== axi_memory_model.sv ====
// behavioural AXI slave memory facing the bridge
`timescale 1ns/1ns
module axi_memory_model (
	input wire logic clk_i,
	input memtest_pkg::axi_addr_t aw_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input memtest_pkg::axi_w_t w_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input memtest_pkg::axi_addr_t ar_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output memtest_pkg::axi_r_t r_o,
	input wire logic rready_i
	,output logic rvalid_o
);
	logic [63:0] mem_q [logic [31:0]];
	logic [31:0] base;
	logic [7:0] n;
	logic wr;
	initial begin
		{awready_o, wready_o, bvalid_o, arready_o, rvalid_o} = 5'h00;
		r_o = '0;
		forever begin
			// unknown valids before the first reset edge are not requests
			do @(posedge clk_i); while (awvalid_i !== 1'b1 && arvalid_i !== 1'b1);
			wr = awvalid_i;
			base = wr ? aw_i.addr : ar_i.addr;
			n = wr ? aw_i.len : ar_i.len;
			repeat ($urandom_range(2)) @(posedge clk_i);
			#1 awready_o = wr;
			arready_o = !wr;
			@(posedge clk_i);
			#1 {awready_o, arready_o} = 2'h0;
			for (int i = 0; i <= n; i++) begin
				repeat ($urandom_range(2)) @(posedge clk_i);
				#1;
				if (wr) begin
					wready_o = 1'b1;
					do @(posedge clk_i); while (!wvalid_i);
					mem_q[base + 8 * i] = w_i.data;
					#1 wready_o = 1'b0;
				end else begin
					// unwritten places answer with a pattern derived from the burst's base address
					r_o.data = mem_q.exists(base + 8 * i) ? mem_q[base + 8 * i] : {base, ~base};
					r_o.last = (i == n);
					rvalid_o = 1'b1;
					do @(posedge clk_i); while (!rready_i);
					#1 rvalid_o = 1'b0;
					r_o.data = ~r_o.data;
				end
			end
			if (wr) begin
				#1 bvalid_o = 1'b1;
				do @(posedge clk_i); while (!bready_i);
				#1 bvalid_o = 1'b0;
			end
		end
	end
endmodule : axi_memory_model

// ==== test_serial_command_wrapper.sv ====
// self-checking bench for the serial command bridge
`timescale 1ns/1ns
`include "memtest_defines.svh"
`define CHECK(g, e) begin logic [127:0] got_v, exp_v; got_v = 128'(g); exp_v = 128'(e); num_checks++; \
	if (got_v !== exp_v) begin error_cnt++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, got_v, exp_v); end end
module test_serial_command_wrapper;
	logic sys_clk_i, resetn_i, rx_i, tx_o;
	memtest_pkg::axi_addr_t aw_o, ar_o;
	memtest_pkg::axi_w_t w_o;
	memtest_pkg::axi_r_t r_i;
	logic awvalid_o, awready_i, wvalid_o, wready_i, bvalid_i, bready_o, arvalid_o, arready_i, rvalid_i, rready_o;
	int error_cnt = 0, num_checks = 0;
	logic [39:0] exp_a [$];
	logic [64:0] exp_w [$];
	logic [7:0] exp_b [$];
	logic [31:0] addr;
	logic [63:0] data;
	// short bit period keeps the run brief; the logic is the same at any rate
	localparam int BAUD_DIV = 32;
	serial_command_wrapper #(.BAUD_DIV(BAUD_DIV)) DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .rx_i(rx_i),
		.tx_o(tx_o),
		.aw_o(aw_o), .awvalid_o(awvalid_o), .awready_i(awready_i), .w_o(w_o), .wvalid_o(wvalid_o),
		.wready_i(wready_i), .bvalid_i(bvalid_i), .bready_o(bready_o), .ar_o(ar_o), .arvalid_o(arvalid_o),
		.arready_i(arready_i), .r_i(r_i), .rvalid_i(rvalid_i), .rready_o(rready_o));
	axi_memory_model memory_model (.clk_i(sys_clk_i), .aw_i(aw_o), .awvalid_i(awvalid_o), .awready_o(awready_i),
		.w_i(w_o), .wvalid_i(wvalid_o), .wready_o(wready_i), .bvalid_o(bvalid_i), .bready_i(bready_o),
		.ar_i(ar_o), .arvalid_i(arvalid_o), .arready_o(arready_i), .r_o(r_i), .rready_i(rready_o),
		.rvalid_o(rvalid_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// ----------------------------------------
	// watchers: oldest note against each result
	// ----------------------------------------
	function automatic logic [44:0] next_addr();
		logic [39:0] v;
		v = exp_a.size() ? exp_a.pop_front() : 40'hx;
		return {v, `AXI_SIZE_8B, `AXI_BURST_INCR};
	endfunction : next_addr
	function automatic logic [72:0] next_w();
		logic [64:0] v;
		v = exp_w.size() ? exp_w.pop_front() : 65'hx;
		return {v[64:1], `AXI_STRB_ALL, v[0]};
	endfunction : next_w
	always @(posedge sys_clk_i) begin
		if (awvalid_o && awready_i)
			`CHECK(aw_o, next_addr())
		if (arvalid_o && arready_i)
			`CHECK(ar_o, next_addr())
		if (wvalid_o && wready_i)
			`CHECK(w_o, next_w())
	end
	initial begin : tx_watch
		logic [7:0] b;
		wait (resetn_i);
		forever begin
			@(negedge tx_o);
			repeat (BAUD_DIV / 2) @(negedge sys_clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BAUD_DIV) @(negedge sys_clk_i);
				b[i] = tx_o;
			end
			repeat (BAUD_DIV) @(negedge sys_clk_i);
			`CHECK(tx_o, 1'b1)
			`CHECK(b, exp_b.size() ? exp_b.pop_front() : 'x)
		end
	end
	// ----------------------------------------
	// host side serial driver
	// ----------------------------------------
	task automatic send_byte(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			#2 rx_i = f[i];
			repeat (BAUD_DIV) @(posedge sys_clk_i);
		end
	endtask : send_byte
	task automatic send_cmd(input logic [7:0] cmd, input logic [31:0] a, input logic [63:0] d);
		send_byte(cmd);
		for (int i = 3; i >= 0; i--) send_byte(a[8 * i +: 8]);
		if (cmd[`CMD_WRITE_BIT])
			for (int i = 7; i >= 0; i--) send_byte(d[8 * i +: 8]);
	endtask : send_cmd
	task automatic drain(input string name);
		for (int i = 0; i < 50000 && (exp_a.size() || exp_w.size() || exp_b.size()); i++) @(posedge sys_clk_i);
		repeat (20) @(posedge sys_clk_i);
		`CHECK(exp_a.size() + exp_w.size() + exp_b.size(), 0)
		$display("test %s done", name);
	endtask : drain
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	initial begin
		// about twice the serial traffic of all tests together
		repeat (12 * 130 * BAUD_DIV) @(posedge sys_clk_i);
		error_cnt++;
		complete_run();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rx_i = 1'b1;
		resetn_i = 1'b0;
		void'($urandom(2));
		repeat (5) @(posedge sys_clk_i);
		`CHECK({tx_o, awvalid_o, wvalid_o, arvalid_o, rready_o, bready_o}, 6'h20)
		#2 resetn_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		addr = $urandom & 32'h03ff_f800;
		data = {$urandom, $urandom};
		exp_a.push_back({addr, 8'h00});
		exp_w.push_back({data, 1'b1});
		send_cmd(8'h01, addr, data);
		drain("single write");
		for (int k = 0; k < 16; k++) begin
			exp_a.push_back({addr + 32'h100 + 32'h80 * k, 8'h0f});
			for (int j = 0; j < 16; j++)
				exp_w.push_back({data + 64'h1 + 64'(16 * k + j), j == 15});
		end
		send_cmd(8'h03, addr + 32'h100, data + 64'h1);
		drain("burst write");
		exp_a.push_back({addr, 8'h00});
		for (int i = 7; i >= 0; i--) exp_b.push_back(data[8 * i +: 8]);
		send_cmd(8'h00, addr, 64'h0);
		// a stray command byte during readback must be dropped
		send_byte(8'h03);
		drain("single read");
		data = data + 64'h1;
		for (int k = 0; k < 16; k++)
			exp_a.push_back({addr + 32'h100 + 32'h80 * k, 8'h0f});
		for (int i = 7; i >= 0; i--) exp_b.push_back(data[8 * i +: 8]);
		send_cmd(8'h02, addr + 32'h100, 64'h0);
		// full readback is too long for the run; cut it by a reset after the first word
		for (int i = 0; i < 50000 && (exp_a.size() || exp_b.size()); i++) @(posedge sys_clk_i);
		#2 resetn_i = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		`CHECK({tx_o, awvalid_o, wvalid_o, arvalid_o, rready_o, bready_o}, 6'h20)
		#2 resetn_i = 1'b1;
		$display("test burst read done");
		repeat (8) @(posedge sys_clk_i);
		exp_a.push_back({addr + 32'h100, 8'h00});
		for (int i = 7; i >= 0; i--) exp_b.push_back(data[8 * i +: 8]);
		send_cmd(8'h00, addr + 32'h100, 64'h0);
		drain("read after reset");
		complete_run();
	end
endmodule : test_serial_command_wrapper
